// *** src/tcl_consts.svh ***
// Register offsets, field positions and reset values of the lane mode block
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TCL_OFF_PIN_ARR 6'h00
`define TCL_OFF_LANE_LIVE 6'h04
`define TCL_OFF_PORT_CFG 6'h08
`define TCL_OFF_LANE0_SEL 6'h0C
`define TCL_OFF_LANE1_SEL 6'h10
`define TCL_OFF_DECODE_STAT 6'h14
`define TCL_OFF_SW_HS 6'h18
`define TCL_OFF_UC_HS 6'h1C
`define TCL_OFF_APPLY 6'h20
`define TCL_OFF_MAIN_LANE_EN 6'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCL_FLD_LIVE_LSB 16
`define TCL_FLD_WIDTH_LSB 4
`define TCL_FLD_SINGLE 0
`define TCL_FLD_DUAL 1
`define TCL_FLD_VALID 4
`define TCL_FLD_ACT0_LSB 8
`define TCL_FLD_ACT1_LSB 10
`define TCL_FLD_OWN_REQ 0
`define TCL_FLD_AUX_REQ 1
`define TCL_FLD_STATE_LSB 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCL_RST_PIN_ARR 16'h0000
`define TCL_RST_LANE_CODE 16'h0000
`define TCL_RST_LIVE 4'h0
`define TCL_RST_LANE_SEL 2'h0
`define TCL_RST_MAIN_LANE_EN 2'h0

// ----------------------------------------------------------------
// Connector codes
// ----------------------------------------------------------------
`define TCL_PA_FIXED 4'h0
`define TCL_PA_A 4'h1
`define TCL_PA_B 4'h2
`define TCL_PA_C 4'h3
`define TCL_PA_D 4'h4
`define TCL_PA_E 4'h5
`define TCL_PA_F 4'h6
`define TCL_LA_ALL 4'hF
`define TCL_LA_A_ACT 4'h5
`define TCL_LA_HI 4'hC
`define TCL_LA_LO 4'h3
`define TCL_LA_B_ACT 4'h4
`define TCL_LA_B_ACT_FLIP 4'h1

`endif

// *** src/tcl_pkg.sv ***
// Types shared by the lane mode block
package tcl_pkg;

   typedef enum logic [1:0] {
      TCL_W_X1 = 2'h0,
      TCL_W_X2 = 2'h1,
      TCL_W_X4 = 2'h2,
      TCL_W_HDMI = 2'h3
   } tcl_width_t;

   typedef enum logic [3:0] {
      TCL_ST_IDLE = 4'h1,
      TCL_ST_REQ = 4'h2,
      TCL_ST_OWN = 4'h4,
      TCL_ST_REL = 4'h8
   } tcl_own_state_t;

endpackage

// *** src/tcl_sync3.sv ***
// Three-stage input synchroniser with second and third stage agreement
`timescale 1ns/1ps
module tcl_sync3 (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] din,
   output logic [1:0] dout
);

   logic [1:0] stage1;
   logic [1:0] stage2;
   logic [1:0] stage3;
   logic [1:0] agree;

   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= 2'h0;
         stage2 <= 2'h0;
         stage3 <= 2'h0;
         dout <= 2'h0;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         dout <= (dout & ~agree) | (stage3 & agree);
      end
   end

endmodule

// *** src/tcl_mode_decode.sv ***
// Pin and lane assignment decode into recommended per-lane transmitter modes
`timescale 1ns/1ps
`include "tcl_consts.svh"
module tcl_mode_decode
   import tcl_pkg::*;
(
   input wire logic [3:0] pinCode,
   input wire logic [3:0] laneCode,
   input tcl_width_t width,
   output logic [1:0] dualSel,
   output logic [1:0] singleSel,
   output logic valid
);

   logic isX1;
   logic isX2;
   logic isX4;
   logic laneAll;
   logic laneHiLo;
   logic dualBoth;
   logic singleBoth;
   logic singleLane1;
   logic zeroOk;

   assign isX1 = (width == TCL_W_X1);
   assign isX2 = (width == TCL_W_X2);
   assign isX4 = (width == TCL_W_X4);
   assign laneAll = (laneCode == `TCL_LA_ALL);
   assign laneHiLo = (laneCode == `TCL_LA_HI) || (laneCode == `TCL_LA_LO);

   // Lane code chooses nothing per flip; lane enables cancel it out
   assign dualBoth =
      ((pinCode == `TCL_PA_A) && laneAll && isX4) ||
      ((pinCode == `TCL_PA_B) && laneHiLo && isX2) ||
      (((pinCode == `TCL_PA_C) || (pinCode == `TCL_PA_E)) && laneAll &&
         (isX4 || isX2)) ||
      (((pinCode == `TCL_PA_D) || (pinCode == `TCL_PA_F)) && laneHiLo &&
         isX2) ||
      ((pinCode == `TCL_PA_FIXED) && !isX1);

   assign singleBoth =
      (((pinCode == `TCL_PA_C) || (pinCode == `TCL_PA_E)) && isX1) ||
      (((pinCode == `TCL_PA_D) || (pinCode == `TCL_PA_F)) && laneHiLo &&
         isX1);

   assign singleLane1 = (pinCode == `TCL_PA_FIXED) && isX1;

   assign zeroOk =
      ((pinCode == `TCL_PA_A) && (isX2 || isX1) &&
         (laneAll || (laneCode == `TCL_LA_A_ACT))) ||
      ((pinCode == `TCL_PA_B) && isX1 && (laneHiLo ||
         (laneCode == `TCL_LA_B_ACT) ||
         (laneCode == `TCL_LA_B_ACT_FLIP)));

   assign dualSel = {dualBoth, dualBoth};
   assign singleSel = {singleBoth | singleLane1, singleBoth};
   assign valid = dualBoth | singleBoth | singleLane1 | zeroOk;

endmodule

// *** src/tcl_lane_mode.sv ***
// Lane mode select top: register file, decode, handshake and lane outputs
// Notes on behaviour
// - Two lane-mode registers per PHY, each with dual and single select bits.
// - Both clear: TX1 only; single only: TX2; dual set: TX1 and TX2.
// - Mode values come from pin code, quad lane code and port width only.
// - Lane enables shut the unused lane; modes equal for flipped cases.
// - Pin 0x1, lane 0xF, four lanes: dual set, single clear both lanes.
// - Pin 0x1 at two or one lane, lane 0xF or 0x5: all bits clear.
// - Pin 0x2 two lanes, lane 0xC or 0x3: dual set both lanes.
// - Pin 0x2 one lane, lane 0xC, 0x3, 0x4 or 0x1: all clear.
// - Pin 0x3 or 0x5, lane 0xF, four or two lanes: dual both lanes.
// - Pin 0x3 or 0x5 one lane: single set both lanes.
// - Pin 0x4 or 0x6 two lanes, lane 0xC or 0x3: dual both lanes.
// - Pin 0x4 or 0x6 one lane, lane 0xC or 0x3: single both lanes.
// - Pin 0x0 at four, HDMI or two lanes: dual both, lane code ignored.
// - Pin 0x0 one lane: single on lane one only, lane zero clear.
// - Ownership handshake around connect and disconnect sets power state.
// - Connector lanes routed by one of six pin arrangements.
// - Connector indices 0 to 3 map directly to ports 1 to 4.
`timescale 1ns/1ps
`include "tcl_consts.svh"
module tcl_lane_mode
   import tcl_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ucOwnAck,
   input wire logic ucAuxAck,
   output logic ownReqOut,
   output logic portPowerOn,
   output logic auxPowerReq,
   output logic [1:0] phyLaneEn,
   output logic lane0Tx1En,
   output logic lane0Tx2En,
   output logic lane1Tx1En,
   output logic lane1Tx2En
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [15:0] pinArr;
   logic [15:0] laneCodes;
   logic [3:0] liveState;
   logic [1:0] portIdx;
   tcl_width_t portWidth;
   logic [1:0] lane0Sel;
   logic [1:0] lane1Sel;
   logic swOwnReq;
   logic swAuxReq;
   logic [1:0] mainLaneEn;
   logic rdReady;
   tcl_own_state_t ownState;
   tcl_own_state_t next_ownState;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire wrPinArr = avs_write && (avs_address == `TCL_OFF_PIN_ARR);
   wire wrLaneLive = avs_write && (avs_address == `TCL_OFF_LANE_LIVE);
   wire wrPortCfg = avs_write && (avs_address == `TCL_OFF_PORT_CFG);
   wire wrLane0 = avs_write && (avs_address == `TCL_OFF_LANE0_SEL);
   wire wrLane1 = avs_write && (avs_address == `TCL_OFF_LANE1_SEL);
   wire wrSwHs = avs_write && (avs_address == `TCL_OFF_SW_HS);
   wire wrApply = avs_write && (avs_address == `TCL_OFF_APPLY) &&
      avs_byteenable[0] && avs_writedata[0];
   wire wrMainEn = avs_write && (avs_address == `TCL_OFF_MAIN_LANE_EN);
   wire rdTake = avs_read && !rdReady;

   wire [31:0] curPortCfg = {26'h0, portWidth, 2'h0, portIdx};
   wire [31:0] curLaneLive = {12'h0, liveState, laneCodes};
   wire [31:0] mrgPinArr = ({16'h0, pinArr} & ~beMask) |
      (avs_writedata & beMask);
   wire [31:0] mrgLaneLive = (curLaneLive & ~beMask) |
      (avs_writedata & beMask);
   wire [31:0] mrgPortCfg = (curPortCfg & ~beMask) |
      (avs_writedata & beMask);

   // ----------------------------------------------------------------
   // Selected connector fields
   // ----------------------------------------------------------------
   // Port n+1 reads connector n fields
   wire [3:0] selPinCode = pinArr[{portIdx, 2'h0} +: 4];
   wire [3:0] selLaneCode = laneCodes[{portIdx, 2'h0} +: 4];
   wire selLive = liveState[portIdx];

   logic [1:0] recDual;
   logic [1:0] recSingle;
   logic recValid;

   tcl_mode_decode u_decode (
      .pinCode(selPinCode),
      .laneCode(selLaneCode),
      .width(portWidth),
      .dualSel(recDual),
      .singleSel(recSingle),
      .valid(recValid)
   );

   // ----------------------------------------------------------------
   // Handshake input crossing
   // ----------------------------------------------------------------
   logic [1:0] ackSync;

   tcl_sync3 u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din({ucAuxAck, ucOwnAck}),
      .dout(ackSync)
   );

   wire ownAckS = ackSync[0];
   wire auxAckS = ackSync[1];

   // ----------------------------------------------------------------
   // Transmitter decode of held mode bits
   // ----------------------------------------------------------------
   wire next_l0Tx1 = !lane0Sel[`TCL_FLD_SINGLE] ||
      lane0Sel[`TCL_FLD_DUAL];
   wire next_l0Tx2 = lane0Sel[`TCL_FLD_SINGLE] ||
      lane0Sel[`TCL_FLD_DUAL];
   wire next_l1Tx1 = !lane1Sel[`TCL_FLD_SINGLE] ||
      lane1Sel[`TCL_FLD_DUAL];
   wire next_l1Tx2 = lane1Sel[`TCL_FLD_SINGLE] ||
      lane1Sel[`TCL_FLD_DUAL];
   wire [1:0] recLane0 = {recDual[0], recSingle[0]};
   wire [1:0] recLane1 = {recDual[1], recSingle[1]};

   // ----------------------------------------------------------------
   // Ownership state machine
   // ----------------------------------------------------------------
   always_comb begin
      next_ownState = ownState;
      case (ownState)
         TCL_ST_IDLE: begin
            if (swOwnReq) begin
               next_ownState = TCL_ST_REQ;
            end
         end
         TCL_ST_REQ: begin
            if (!swOwnReq) begin
               next_ownState = TCL_ST_REL;
            end else if (ownAckS) begin
               next_ownState = TCL_ST_OWN;
            end
         end
         TCL_ST_OWN: begin
            if (!swOwnReq) begin
               next_ownState = TCL_ST_REL;
            end
         end
         TCL_ST_REL: begin
            if (!ownAckS) begin
               next_ownState = TCL_ST_IDLE;
            end
         end
         default: begin
            next_ownState = TCL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ownState <= TCL_ST_IDLE;
      end else begin
         ownState <= next_ownState;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinArr <= `TCL_RST_PIN_ARR;
         laneCodes <= `TCL_RST_LANE_CODE;
         liveState <= `TCL_RST_LIVE;
         portIdx <= 2'h0;
         portWidth <= TCL_W_X1;
      end else begin
         if (wrPinArr) begin
            pinArr <= mrgPinArr[15:0];
         end
         if (wrLaneLive) begin
            laneCodes <= mrgLaneLive[15:0];
            liveState <= mrgLaneLive[`TCL_FLD_LIVE_LSB +: 4];
         end
         if (wrPortCfg) begin
            portIdx <= mrgPortCfg[1:0];
            portWidth <= tcl_width_t'(mrgPortCfg[`TCL_FLD_WIDTH_LSB +: 2]);
         end
      end
   end

   // Modes move only on a direct write or an apply of a valid decode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lane0Sel <= `TCL_RST_LANE_SEL;
         lane1Sel <= `TCL_RST_LANE_SEL;
      end else if (wrApply && recValid) begin
         lane0Sel <= recLane0;
         lane1Sel <= recLane1;
      end else begin
         if (wrLane0 && avs_byteenable[0]) begin
            lane0Sel <= avs_writedata[1:0];
         end
         if (wrLane1 && avs_byteenable[0]) begin
            lane1Sel <= avs_writedata[1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         swOwnReq <= 1'b0;
         swAuxReq <= 1'b0;
         mainLaneEn <= `TCL_RST_MAIN_LANE_EN;
      end else begin
         if (wrSwHs && avs_byteenable[0]) begin
            swOwnReq <= avs_writedata[`TCL_FLD_OWN_REQ];
            swAuxReq <= avs_writedata[`TCL_FLD_AUX_REQ];
         end
         if (wrMainEn && avs_byteenable[0]) begin
            mainLaneEn <= avs_writedata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire [31:0] decodeStat = {20'h0, next_l1Tx2, next_l1Tx1, next_l0Tx2,
      next_l0Tx1, 3'h0, recValid, recLane1, recLane0};
   wire [31:0] swHsVal = {30'h0, swAuxReq, swOwnReq};
   wire [31:0] ucHsVal = {24'h0, ownState, 2'h0, auxAckS, ownAckS};
   wire [31:0] rdMux =
      (avs_address == `TCL_OFF_PIN_ARR) ? {16'h0, pinArr} :
      (avs_address == `TCL_OFF_LANE_LIVE) ? curLaneLive :
      (avs_address == `TCL_OFF_PORT_CFG) ? curPortCfg :
      (avs_address == `TCL_OFF_LANE0_SEL) ? {30'h0, lane0Sel} :
      (avs_address == `TCL_OFF_LANE1_SEL) ? {30'h0, lane1Sel} :
      (avs_address == `TCL_OFF_DECODE_STAT) ? decodeStat :
      (avs_address == `TCL_OFF_SW_HS) ? swHsVal :
      (avs_address == `TCL_OFF_UC_HS) ? ucHsVal :
      (avs_address == `TCL_OFF_MAIN_LANE_EN) ? {30'h0, mainLaneEn} :
      32'h0;

   assign avs_waitrequest = avs_read && !rdReady;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdReady <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rdReady <= rdTake;
         if (rdTake) begin
            avs_readdata <= rdMux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the PHY and port controller
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lane0Tx1En <= 1'b1;
         lane0Tx2En <= 1'b0;
         lane1Tx1En <= 1'b1;
         lane1Tx2En <= 1'b0;
         phyLaneEn <= 2'h0;
         ownReqOut <= 1'b0;
         portPowerOn <= 1'b0;
         auxPowerReq <= 1'b0;
      end else begin
         lane0Tx1En <= next_l0Tx1;
         lane0Tx2En <= next_l0Tx2;
         lane1Tx1En <= next_l1Tx1;
         lane1Tx2En <= next_l1Tx2;
         // Unused lane is shut here, not through the mode bits
         phyLaneEn <= mainLaneEn;
         ownReqOut <= (next_ownState == TCL_ST_REQ) ||
            (next_ownState == TCL_ST_OWN);
         portPowerOn <= (next_ownState == TCL_ST_OWN);
         // Guard against aux power on a port that is not live
         auxPowerReq <= swAuxReq && selLive;
      end
   end

endmodule

// *** sim/tcl_lane_mode_assertions.sv ***
// Port-level temporal checks of the lane mode block
`timescale 1ns/1ps
module tcl_lane_mode_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic ucOwnAck,
   input wire logic ownReqOut,
   input wire logic portPowerOn,
   input wire logic auxPowerReq,
   input wire logic [1:0] phyLaneEn,
   input wire logic lane0Tx1En,
   input wire logic lane0Tx2En,
   input wire logic lane1Tx1En,
   input wire logic lane1Tx2En
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_read_wait: assert property (
      $rose(avs_read) |-> avs_waitrequest)
      else $error("read not held for a wait state");
   chk_one_wait: assert property (
      avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read wait longer than one cycle");
   chk_write_nowait: assert property (
      avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   chk_tx_alive: assert property (
      (lane0Tx1En | lane0Tx2En) && (lane1Tx1En | lane1Tx2En))
      else $error("lane with no transmitter");
   chk_lane_write: assert property (
      $changed({lane0Tx1En, lane0Tx2En, lane1Tx1En, lane1Tx2En}) |->
      $past(avs_write) || $past(avs_write, 2))
      else $error("lane mode changed without write");
   chk_lane_en_write: assert property (
      $changed(phyLaneEn) |-> $past(avs_write) || $past(avs_write, 2))
      else $error("lane enable changed without write");
   chk_aux_write: assert property (
      $changed(auxPowerReq) |-> $past(avs_write) || $past(avs_write, 2))
      else $error("aux request changed without write");
   chk_power_own: assert property (
      portPowerOn |-> ownReqOut)
      else $error("power on without ownership request");
   chk_power_ack: assert property (
      $rose(portPowerOn) |-> ucOwnAck && $past(ucOwnAck, 3))
      else $error("power on before settled grant");
   cov_power: cover property ($rose(portPowerOn));
   cov_aux: cover property ($rose(auxPowerReq));
   cov_tx2: cover property ($rose(lane1Tx2En) && !lane0Tx2En);
endmodule

bind tcl_lane_mode tcl_lane_mode_chk tcl_lane_mode_chk_inst (.clk(clk),
   .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .ucOwnAck(ucOwnAck),
   .ownReqOut(ownReqOut), .portPowerOn(portPowerOn),
   .auxPowerReq(auxPowerReq), .phyLaneEn(phyLaneEn),
   .lane0Tx1En(lane0Tx1En), .lane0Tx2En(lane0Tx2En),
   .lane1Tx1En(lane1Tx1En), .lane1Tx2En(lane1Tx2En));

// *** sim/tcl_uc_model.sv ***
// Behavioural port microcontroller answering ownership and aux requests
`timescale 1ns/1ps
module tcl_uc_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic ownReq,
   input wire logic auxReq,
   output logic ownAck,
   output logic auxAck
);
   logic [4:0] ownCnt;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ownCnt <= 5'h00;
         ownAck <= 1'b0;
         auxAck <= 1'b0;
      end else begin
         // Grant after a wait while requested, withdraw at once
         ownCnt <= !ownReq ? 5'h00 : ownCnt + {4'h0, ownCnt != 5'h1F};
         ownAck <= ownReq && (ownCnt >= (slow ? 5'h14 : 5'h02));
         auxAck <= auxReq;
      end
   end
endmodule

// *** sim/tb_top.sv ***
// Self-checking testbench of the lane mode block
`timescale 1ns/1ps
`include "tcl_consts.svh"
module tb_top;
   import tcl_pkg::*;
   logic clk, arst_n, avs_read, avs_write, avs_waitrequest, slow;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable, txNow, held;
   logic ucOwnAck, ucAuxAck, ownReqOut, portPowerOn, auxPowerReq;
   logic [1:0] phyLaneEn;
   logic lane0Tx1En, lane0Tx2En, lane1Tx1En, lane1Tx2En;
   int failCount, checked;
   assign txNow = {lane1Tx2En, lane1Tx1En, lane0Tx2En, lane0Tx1En};

   tcl_lane_mode tcl_lane_mode_inst (.clk(clk), .arst_n(arst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ucOwnAck(ucOwnAck),
      .ucAuxAck(ucAuxAck), .ownReqOut(ownReqOut),
      .portPowerOn(portPowerOn), .auxPowerReq(auxPowerReq),
      .phyLaneEn(phyLaneEn), .lane0Tx1En(lane0Tx1En),
      .lane0Tx2En(lane0Tx2En), .lane1Tx1En(lane1Tx1En),
      .lane1Tx2En(lane1Tx2En));
   tcl_uc_model tcl_uc_model_inst (.clk(clk), .arst_n(arst_n),
      .slow(slow), .ownReq(ownReqOut), .auxReq(auxPowerReq),
      .ownAck(ucOwnAck), .auxAck(ucAuxAck));

   // ------
   // Bus and compare tasks
   // ------
   task automatic bus(input logic rd, input logic [5:0] a,
         input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= !rd;
      // Only the watchdog ends a wait that never finishes
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check_word(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Per lane {tx2, tx1} from {dual, single}
   function automatic logic [3:0] txOf(input logic [3:0] h);
      return {h[3] | h[2], h[3] | !h[2], h[1] | h[0], h[1] | !h[0]};
   endfunction

   // ------
   // Scenarios
   // ------
   task automatic test_reset;
      bus(1'b1, `TCL_OFF_LANE0_SEL, 32'h0);
      check_word("lane0 sel", 32'h0, q);
      bus(1'b1, `TCL_OFF_LANE1_SEL, 32'h0);
      check_word("lane1 sel", 32'h0, q);
      check_word("tx", 32'h5, {28'h0, txNow});
      check_word("outs", 32'h0, {27'h0, phyLaneEn, ownReqOut, portPowerOn,
         auxPowerReq});
   endtask
   task automatic test_tx;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, `TCL_OFF_LANE0_SEL, i);
         bus(1'b0, `TCL_OFF_LANE1_SEL, 3 - i);
         held = {2'(3 - i), 2'(i)};
         idle(2);
         check_word("tx direct", {28'h0, txOf(held)}, {28'h0, txNow});
         bus(1'b1, `TCL_OFF_LANE0_SEL, 32'h0);
         check_word("sel back", i, q);
      end
   endtask
   // {pin, lane, invalid, 0, width, expected dual/single per lane}
   logic [15:0] tbl [20] = '{16'h1F2A, 16'h1F10, 16'h1500, 16'h2C1A,
      16'h231A, 16'h2400, 16'h2100, 16'h2C00, 16'h3F2A, 16'h5F1A,
      16'h3F05, 16'h5F05, 16'h4C1A, 16'h631A, 16'h4305, 16'h6C05,
      16'h073A, 16'h0F2A, 16'h0F04, 16'h15A0};
   task automatic test_table;
      logic [15:0] e;
      int sh;
      for (int i = 0; i < 20; i++) begin
         e = tbl[i];
         sh = 4 * (i % 4);
         bus(1'b0, `TCL_OFF_PIN_ARR, {28'h0, e[15:12]} << sh);
         bus(1'b0, `TCL_OFF_LANE_LIVE, {28'h0, e[11:8]} << sh);
         bus(1'b0, `TCL_OFF_PORT_CFG, {26'h0, e[5:4], 2'h0, 2'(i % 4)});
         bus(1'b1, `TCL_OFF_DECODE_STAT, 32'h0);
         check_word("decode", {27'h0, !e[7], e[3:0]},
            q & 32'h1F);
         bus(1'b0, `TCL_OFF_APPLY, 32'h1);
         if (!e[7]) held = e[3:0];
         idle(2);
         check_word("tx applied", {28'h0, txOf(held)}, {28'h0, txNow});
      end
   endtask
   task automatic test_refuse;
      bus(1'b0, 6'h28, 32'hFFFF_FFFF);
      bus(1'b1, 6'h28, 32'h0);
      check_word("unmapped", 32'h0, q);
      bus(1'b0, `TCL_OFF_UC_HS, 32'hFFFF_FFFF);
      bus(1'b1, `TCL_OFF_UC_HS, 32'h0);
      check_word("uc idle", 32'h10, q);
   endtask
   task automatic test_own;
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         bus(1'b0, `TCL_OFF_SW_HS, 32'h1);
         for (int n = 0; n < 100 && portPowerOn !== 1'b1; n++) idle(1);
         check_word("owned", 32'h3, {30'h0, ownReqOut, portPowerOn});
         bus(1'b1, `TCL_OFF_UC_HS, 32'h0);
         check_word("uc own", 32'h41, q);
         bus(1'b0, `TCL_OFF_SW_HS, 32'h0);
         idle(2);
         check_word("released", 32'h0, {30'h0, ownReqOut, portPowerOn});
         idle(20);
         bus(1'b1, `TCL_OFF_UC_HS, 32'h0);
         check_word("uc back", 32'h10, q);
      end
   endtask
   task automatic test_aux;
      bus(1'b0, `TCL_OFF_PORT_CFG, 32'h1);
      bus(1'b0, `TCL_OFF_SW_HS, 32'h2);
      idle(2);
      check_word("aux unplugged", 32'h0, {31'h0, auxPowerReq});
      bus(1'b0, `TCL_OFF_LANE_LIVE, 32'h0002_0000);
      idle(2);
      check_word("aux live", 32'h1, {31'h0, auxPowerReq});
      // Acknowledge needs the partner edge and the input crossing
      idle(6);
      bus(1'b1, `TCL_OFF_UC_HS, 32'h0);
      check_word("uc aux", 32'h12, q);
      bus(1'b0, `TCL_OFF_LANE_LIVE, 32'h0);
      idle(2);
      check_word("aux gone", 32'h0, {31'h0, auxPowerReq});
      bus(1'b0, `TCL_OFF_MAIN_LANE_EN, 32'h2);
      idle(2);
      check_word("lane en", 32'h2, {30'h0, phyLaneEn});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #40000;
      failCount++;
      tally_and_finish();
   end
   initial begin
      arst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      slow = 1'b0;
      failCount = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      test_reset();
      test_tx();
      test_table();
      test_refuse();
      test_own();
      test_aux();
      tally_and_finish();
   end
endmodule
